// *** inc/vgc_pkg.sv ***
/*
 * vgc_pkg: shared constants and types for the vco gain calibration sequencer.
 * assumes a single 40 MHz reference clock and a plain address/strobe register port.
 */
package vgc_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;            // 40 MHz reference
    localparam int GAP_TIME_NS = 1000;            // spacing between plain steps
    localparam int SETTLE_TIME_NS = 10000;        // vco settle after a prescaler change
    localparam int CONV_TIME_NS = 40000;          // converter conversion time (least)
    localparam longint TEST_PERIOD_NS = 100000000; // repeat interval in test mode
    // least times round up to whole cycles
    localparam int GAP_CYC = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TEST_PERIOD_CYC = int'(TEST_PERIOD_NS / CLK_PERIOD_NS);
    localparam int TMR_W = 16;                    // step timer width
    localparam int TEST_W = 23;                   // test period counter width

    // ------------------------------------------------------------
    // frequency grid (frequency word in kHz)
    // ------------------------------------------------------------
    localparam int FREQ_W = 17;
    localparam logic [FREQ_W-1:0] GRID_STEP_KHZ = 17'h000C8;   // 200 kHz
    localparam logic [FREQ_W-1:0] OFFSET_EDGE_KHZ = 17'h14820; // 84 MHz
    localparam logic [FREQ_W-1:0] FREQ_RESET_KHZ = 17'h0EA60;  // 60 MHz

    // ------------------------------------------------------------
    // converter, dac and prescaler
    // ------------------------------------------------------------
    localparam int ADC_W = 8;
    localparam logic [ADC_W-1:0] DAC_DEFAULT = 8'hBF;    // 191/256 while blanked
    localparam logic [3:0] PRESC_ADD = 4'h9;             // extra count high
    localparam logic [3:0] PRESC_NORM = 4'hA;            // extra count low

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_FREQ = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam int CTRL_GATE_N = 0;     // idle modulation gate (active low)
    localparam int CTRL_DC_SEL = 1;     // idle dc-coupled select
    localparam int CTRL_TEST = 2;       // repeatable calibration mode
    localparam int CTRL_START = 3;      // write 1: request a cycle
    localparam int ST_BUSY = 0;
    localparam int ST_PEND = 1;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_DAC_LSB = 8;

    // ------------------------------------------------------------
    // sequencer states, one per timed step
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        VGC_IDLE = 4'h0,
        VGC_T1 = 4'h1,
        VGC_T2 = 4'h2,
        VGC_T3 = 4'h3,
        VGC_T4 = 4'h4,
        VGC_T5 = 4'h5,
        VGC_T6 = 4'h6,
        VGC_T7 = 4'h7,
        VGC_T8 = 4'h8
    } vgc_state_t;

    // control bits toward loop, prescaler, switch and converter
    typedef struct packed {
        logic dc_coupled_mod_select;
        logic modulation_gate_n;
        logic extra_count;
        logic sample_hold_ctl_n;
        logic blank_convert;
    } vgc_ctl_t;
endpackage : vgc_pkg

// *** design/vgc_step_timer.sv ***
/*
 * vgc_step_timer: loadable down counter that flags expiry of a step wait.
 * assumes load and count come from logic on the same clock.
 */
`timescale 1ns/1ps
module vgc_step_timer
    import vgc_pkg::*;
#(
    parameter int W = TMR_W
)
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_load,          // start a new wait
    input wire logic [W-1:0] i_count, // cycles to wait, at least one
    output logic o_expired           // level, high once the wait is over
);
    logic [W-1:0] cnt; // remaining cycles

    // ------------------------------------------------------------
    // count down, expiry flag
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt <= '0;
            o_expired <= 1'b1;
        end
        else if (i_load)
        begin
            // new wait clears expiry at once
            cnt <= i_count;
            o_expired <= 1'b0;
        end
        else if (cnt > W'(1))
        begin
            cnt <= cnt - W'(1);
        end
        else
        begin
            cnt <= '0;
            o_expired <= 1'b1;
        end
    end
endmodule : vgc_step_timer

// *** design/vgc_seq.sv ***
/*
 * vgc_seq: vco gain calibration sequencer with register port.
 * assumes a free 40 MHz clock, converter data arriving on pins, one master on the port.
 */
`timescale 1ns/1ps
module vgc_seq
    import vgc_pkg::*;
#(
    parameter int TEST_CYC = TEST_PERIOD_CYC, // repeat interval, cycles
    parameter int SETTLE_CYCLES = SETTLE_CYC   // vco settle wait, cycles
)
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic [ADC_W-1:0] i_adc_data,
    output logic o_dc_coupled_mod_select,
    output logic o_modulation_gate_n,
    output logic o_extra_count,
    output logic o_sample_hold_ctl_n,
    output logic o_blank_convert,
    output logic [3:0] o_prescale_mod,
    output logic [ADC_W-1:0] o_cal_dac,
    output logic o_offset_select_bit,
    output logic o_busy
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // grid slot of a frequency word
    function automatic logic [FREQ_W-1:0] grid_slot(input logic [FREQ_W-1:0] f);
        grid_slot = f / GRID_STEP_KHZ;
    endfunction : grid_slot

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    vgc_state_t state; // current step
    vgc_state_t next_state; // step after this cycle
    vgc_ctl_t ctl; // driven control bits
    logic adv; // leave current step
    logic tmr_load; // start next wait
    logic [TMR_W-1:0] tmr_count; // length of next wait
    logic tmr_exp; // wait over
    logic ctrl_gate_n; // idle modulation gate
    logic ctrl_dc_sel; // idle dc select
    logic ctrl_test; // repeatable mode
    logic [FREQ_W-1:0] freq; // programmed frequency, kHz
    logic crossing; // grid boundary crossed
    logic pending; // cycle request waiting
    logic saved_gate_n; // pre-cycle modulation gate
    logic saved_dc; // pre-cycle dc select
    logic [TEST_W-1:0] test_cnt; // test interval counter
    logic test_tick; // test interval elapsed
    logic [ADC_W-1:0] adc_s1; // pin sync stage one
    logic [ADC_W-1:0] adc_s2; // pin sync stage two
    logic [ADC_W-1:0] adc_s3; // pin sync stage three
    logic adc_stable; // stages two and three agree
    logic [ADC_W-1:0] result; // latched conversion result
    logic wr_freq; // frequency write
    logic wr_ctrl; // control write

    assign wr_freq = i_wr && (i_addr == REG_FREQ);
    assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
    assign crossing = wr_freq
        && (grid_slot(i_wdata[FREQ_W-1:0]) != grid_slot(freq));
    assign test_tick = ctrl_test && (test_cnt == TEST_W'(TEST_CYC - 1));
    assign adc_stable = (adc_s2 == adc_s3);

    // ------------------------------------------------------------
    // software control and frequency word
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_gate_n <= 1'b1;
            ctrl_dc_sel <= 1'b0;
            ctrl_test <= 1'b0;
            freq <= FREQ_RESET_KHZ;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_gate_n <= i_wdata[CTRL_GATE_N];
                ctrl_dc_sel <= i_wdata[CTRL_DC_SEL];
                ctrl_test <= i_wdata[CTRL_TEST];
            end
            if (wr_freq)
            begin
                freq <= i_wdata[FREQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // test-mode interval counter
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            test_cnt <= '0;
        end
        else if (!ctrl_test || test_tick)
        begin
            test_cnt <= '0;
        end
        else
        begin
            test_cnt <= test_cnt + TEST_W'(1);
        end
    end

    // ------------------------------------------------------------
    // pending request; a new request wins over the clear
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pending <= 1'b0;
        end
        else if (crossing || test_tick || (wr_ctrl && i_wdata[CTRL_START]))
        begin
            pending <= 1'b1;
        end
        else if (state == VGC_IDLE)
        begin
            pending <= 1'b0; // taken up by the start below
        end
    end

    // ------------------------------------------------------------
    // step sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        adv = 1'b0;
        tmr_count = TMR_W'(GAP_CYC);
        case (state)
            VGC_IDLE:
            begin
                adv = pending;
                next_state = VGC_T1;
            end
            VGC_T1:
            begin
                adv = tmr_exp;
                next_state = VGC_T2;
                tmr_count = TMR_W'(SETTLE_CYCLES); // offset frequency settles
            end
            VGC_T2:
            begin
                adv = tmr_exp;
                next_state = VGC_T3;
            end
            VGC_T3:
            begin
                adv = tmr_exp;
                next_state = VGC_T4;
                tmr_count = TMR_W'(SETTLE_CYCLES); // back to target
            end
            VGC_T4:
            begin
                adv = tmr_exp;
                next_state = VGC_T5;
            end
            VGC_T5:
            begin
                adv = tmr_exp;
                next_state = VGC_T6;
                tmr_count = TMR_W'(CONV_CYC);
            end
            VGC_T6:
            begin
                adv = tmr_exp && adc_stable;
                next_state = VGC_T7;
            end
            VGC_T7:
            begin
                adv = tmr_exp;
                next_state = VGC_T8;
            end
            VGC_T8:
            begin
                adv = tmr_exp;
                next_state = VGC_IDLE;
            end
            default:
            begin
                adv = 1'b1;
                next_state = VGC_IDLE;
            end
        endcase
    end

    assign tmr_load = adv;

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= VGC_IDLE;
        end
        else if (adv)
        begin
            state <= next_state;
        end
    end

    vgc_step_timer #(.W(TMR_W)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_expired(tmr_exp)
    );

    // ------------------------------------------------------------
    // control bits per step
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctl <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            saved_gate_n <= 1'b1;
            saved_dc <= 1'b0;
        end
        else if (state == VGC_IDLE && !adv)
        begin
            // idle: follow software, converter blanked
            ctl.dc_coupled_mod_select <= ctrl_dc_sel;
            ctl.modulation_gate_n <= ctrl_gate_n;
        end
        else if (adv)
        begin
            case (next_state)
                VGC_T1:
                begin
                    saved_gate_n <= ctrl_gate_n;
                    saved_dc <= ctrl_dc_sel;
                    ctl.dc_coupled_mod_select <= 1'b1;
                end
                VGC_T2:
                begin
                    ctl.modulation_gate_n <= 1'b1;
                    ctl.extra_count <= 1'b1;
                    ctl.sample_hold_ctl_n <= 1'b0;
                    ctl.blank_convert <= 1'b1;
                end
                VGC_T3:
                begin
                    ctl.sample_hold_ctl_n <= 1'b1;
                end
                VGC_T4:
                begin
                    ctl.extra_count <= 1'b0;
                end
                VGC_T6:
                begin
                    ctl.blank_convert <= 1'b0;
                end
                VGC_T7:
                begin
                    ctl.modulation_gate_n <= saved_gate_n;
                    ctl.blank_convert <= 1'b1; // result held in latch
                end
                VGC_T8:
                begin
                    ctl.dc_coupled_mod_select <= saved_dc;
                end
                default:
                begin
                    ctl <= ctl;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // converter pins: three-stage sync and result latch
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            adc_s1 <= '0;
            adc_s2 <= '0;
            adc_s3 <= '0;
            result <= DAC_DEFAULT;
        end
        else
        begin
            adc_s1 <= i_adc_data;
            adc_s2 <= adc_s1;
            adc_s3 <= adc_s2;
            if (state == VGC_T6 && adv)
            begin
                result <= adc_s3;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_cal_dac <= DAC_DEFAULT;
            o_prescale_mod <= PRESC_NORM;
            o_offset_select_bit <= 1'b1;
            o_busy <= 1'b0;
        end
        else
        begin
            // tri-stated converter leaves pulled-up default
            o_cal_dac <= (state == VGC_T6) ? adc_s3
                : ((state >= VGC_T2 && state <= VGC_T5) ? DAC_DEFAULT : result);
            o_prescale_mod <= ctl.extra_count ? PRESC_ADD : PRESC_NORM;
            o_offset_select_bit <= (freq < OFFSET_EDGE_KHZ);
            o_busy <= (state != VGC_IDLE);
        end
    end

    assign o_dc_coupled_mod_select = ctl.dc_coupled_mod_select;
    assign o_modulation_gate_n = ctl.modulation_gate_n;
    assign o_extra_count = ctl.extra_count;
    assign o_sample_hold_ctl_n = ctl.sample_hold_ctl_n;
    assign o_blank_convert = ctl.blank_convert;

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rdata <= '0;
        end
        else if (i_rd)
        begin
            case (i_addr)
                REG_CTRL: o_rdata <= DATA_W'({ctrl_test, ctrl_dc_sel, ctrl_gate_n});
                REG_FREQ: o_rdata <= DATA_W'(freq);
                REG_STATUS: o_rdata <= DATA_W'({result, state, 2'h0, pending,
                    (state != VGC_IDLE)});
                default: o_rdata <= '0;
            endcase
        end
        else
        begin
            o_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    int unsigned conv_wait; // cycles spent in conversion step
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            conv_wait <= 0;
        else
            conv_wait <= (state == VGC_T6) ? conv_wait + 1 : 0;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    dc_raise_a: assert property (state == VGC_IDLE && adv |=> o_dc_coupled_mod_select)
        else $error("dc select not raised at cycle start");
    gate_off_a: assert property (state == VGC_T2 |-> o_modulation_gate_n)
        else $error("modulation not gated in step two");
    extra_on_a: assert property ((state == VGC_T2 || state == VGC_T3) |-> o_extra_count)
        else $error("extra count low while offsetting");
    presc_mod_a: assert property (##1 o_prescale_mod == ($past(o_extra_count) ? PRESC_ADD
        : PRESC_NORM))
        else $error("prescaler modulus wrong");
    switch_closed_a: assert property (state == VGC_T2 |-> !o_sample_hold_ctl_n)
        else $error("sample switch not closed in step two");
    blank_dac_a: assert property ((state == VGC_T3 && o_blank_convert)
        |-> o_cal_dac == DAC_DEFAULT)
        else $error("dac not at default while blanked");
    hold_open_a: assert property (state == VGC_T4 |-> o_sample_hold_ctl_n && !o_extra_count)
        else $error("hold or extra count wrong in step four");
    conv_start_a: assert property ($fell(o_blank_convert) |-> state == VGC_T6)
        else $error("conversion started outside step six");
    conv_time_a: assert property (state == VGC_T6 && adv |-> conv_wait >= CONV_CYC)
        else $error("result used before conversion time");
    gate_restore_a: assert property (state == VGC_T7 |-> o_modulation_gate_n == saved_gate_n)
        else $error("modulation gate not restored");
    dc_restore_a: assert property (state == VGC_T8 && adv
        |=> o_dc_coupled_mod_select == saved_dc && state == VGC_IDLE)
        else $error("dc select not restored at end");
    offset_sel_a: assert property (##1 o_offset_select_bit == ($past(freq) < OFFSET_EDGE_KHZ))
        else $error("offset select bit wrong");
    pend_keep_a: assert property (crossing && state != VGC_IDLE |=> pending)
        else $error("crossing lost during cycle");

    full_cycle_c: cover property (state == VGC_T8 && adv);
    busy_cross_c: cover property (crossing && state == VGC_T4);
    test_tick_c: cover property (test_tick);
endmodule : vgc_seq

// *** tb/vgc_adc_model.sv ***
/*
 * vgc_adc_model: behavioural converter with its pull network, facing the sequencer.
 * assumes blank/convert from the sequencer and a free reference clock.
 */
`timescale 1ns/1ps
module vgc_adc_model
    import vgc_pkg::*;
#(
    parameter logic [ADC_W-1:0] RESULT = 8'h5A, // converted code
    parameter int CONV = CONV_CYC               // conversion length, cycles
)
(
    input wire logic i_ref_clk,
    input wire logic i_blank_convert,
    output logic [ADC_W-1:0] o_data
);
    int left = 0;          // cycles of conversion still to run
    logic blank_q = 1'b1;  // blank seen last cycle
    initial o_data = DAC_DEFAULT;
    // --------------------------------
    // blank, convert and settle
    // --------------------------------
    always @(posedge i_ref_clk)
    begin
        blank_q <= i_blank_convert;
        if (i_blank_convert)
        begin
            // outputs open, pulls win
            o_data <= DAC_DEFAULT;
            left <= 0;
        end
        else if (blank_q)
        begin
            // falling blank starts a conversion
            left <= CONV;
            o_data <= ~o_data;
        end
        else if (left > 1)
        begin
            // bits not settled yet
            left <= left - 1;
            o_data <= ~o_data;
        end
        else
            o_data <= RESULT;
    end
endmodule : vgc_adc_model

// *** tb/vgc_seq_test.sv ***
/*
 * vgc_seq_test: self-checking bench for the calibration sequencer.
 * assumes the converter model beside it and shortened test and settle counts.
 */
`timescale 1ns/1ps
module vgc_seq_test;
    import vgc_pkg::*;
    localparam logic [ADC_W-1:0] RES = 8'h5A;
    // rows: frequency, expected offset select, expected crossing
    localparam logic [18:0] ROWS [4] = '{{17'h0EA60, 1'b1, 1'b0}, {17'h1481F, 1'b1, 1'b1},
        {17'h14820, 1'b0, 1'b1}, {17'h1ADB0, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata, rd_v;
    logic [ADC_W-1:0] adc, dac;
    logic dc, gate_n, extra, sh_n, blank, offs, busy;
    logic [3:0] pmod;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    always #12.5 clk = ~clk;
    vgc_seq #(.TEST_CYC(200), .SETTLE_CYCLES(10)) dut (.i_ref_clk(clk), .i_rstn(rstn),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_adc_data(adc), .o_dc_coupled_mod_select(dc), .o_modulation_gate_n(gate_n),
        .o_extra_count(extra), .o_sample_hold_ctl_n(sh_n), .o_blank_convert(blank),
        .o_prescale_mod(pmod), .o_cal_dac(dac), .o_offset_select_bit(offs), .o_busy(busy));
    vgc_adc_model #(.RESULT(RES)) adc_far (.i_ref_clk(clk), .i_blank_convert(blank),
        .o_data(adc));
    // --------------------------------
    // shared tasks
    // --------------------------------
    task summarize;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // output by number: 0 dc, 1 extra, 2 blank, else busy
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = dc;
            1: pick = extra;
            2: pick = blank;
            default: pick = busy;
        endcase
    endfunction : pick
    // wait until the output settles at v after an edge; bounded by the run timeout
    task await(input int sel, input logic v);
        while (pick(sel) !== v)
        begin
            @(posedge clk);
            #1;
        end
    endtask : await
    // follow one whole calibration cycle, g is the idle gate level
    task run_cycle(input logic g);
        await(0, 1'b1);
        await(1, 1'b1);
        check("gate_n", gate_n, 1'b1);
        check("sh_n", sh_n, 1'b0);
        check("blank", blank, 1'b1);
        // dac and modulus follow the step one cycle later
        @(posedge clk);
        #1 check("dac", dac, DAC_DEFAULT);
        check("pmod", pmod, PRESC_ADD);
        await(1, 1'b0);
        check("sh_n", sh_n, 1'b1);
        @(posedge clk);
        #1 check("pmod", pmod, PRESC_NORM);
        await(2, 1'b0);
        n = 0;
        while (blank !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("conv wait", n >= CONV_CYC, 1'b1);
        check("dac", dac, RES);
        check("gate_n", gate_n, g);
        check("dc", dc, 1'b1);
        // step seven lasts its gap plus one, then dc goes back
        repeat (GAP_CYC + 1) @(posedge clk);
        #1 check("dc", dc, 1'b0);
        await(3, 1'b0);
    endtask : run_cycle
    // --------------------------------
    // hang guard
    // --------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            summarize();
        end
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        #1 check("reset outs", {dc, gate_n, extra, sh_n, blank, pmod, dac, offs, busy},
            {5'h0B, PRESC_NORM, DAC_DEFAULT, 2'h2});
        @(posedge clk);
        rstn <= 1'b1;
        rd_reg(REG_CTRL, rd_v);
        check("ctrl", rd_v, 32'h1);
        rd_reg(8'h0C, rd_v);
        check("unmapped", rd_v, 32'h0);
        // ordinary frequency steps
        foreach (ROWS[i])
        begin
            wr_reg(REG_FREQ, {15'h0, ROWS[i][18:2]});
            rd_reg(REG_STATUS, rd_v);
            check("offset", offs, ROWS[i][1]);
            check("pending", |rd_v[1:0], ROWS[i][0]);
            if (ROWS[i][0])
                run_cycle(1'b1);
        end
        // start with gate idle low, crossing while busy is held
        wr_reg(REG_CTRL, 32'h8);
        wr_reg(REG_FREQ, 32'h0EA60);
        rd_reg(REG_STATUS, rd_v);
        check("busy pend", rd_v[1:0], 2'h3);
        run_cycle(1'b0);
        run_cycle(1'b0);
        // repeat mode reruns by itself
        wr_reg(REG_CTRL, 32'h5);
        run_cycle(1'b1);
        run_cycle(1'b1);
        summarize();
    end
endmodule : vgc_seq_test
